// [core/grse_pkg.sv]
// package: constants and carrier types for the remote state and fault block
package grse_pkg;

  localparam int GRSE_FAULT_W = 8;
  // fault status word bit positions
  localparam int GRSE_BIT_BAD_OPTION = 0;
  localparam int GRSE_BIT_LOOP = 1;
  localparam int GRSE_BIT_NOT_REMOTE = 2;
  localparam int GRSE_BIT_EARLY_TRIG = 3;
  localparam int GRSE_BIT_OVERRUN = 4;
  localparam int GRSE_BIT_SETUP = 5;
  localparam int GRSE_BIT_MEMORY = 6;
  localparam logic [7:0] GRSE_FAULT_RESET = 8'h00;
  localparam logic [15:0] GRSE_DOUT_RESET = 16'h0000;
  localparam logic [7:0] GRSE_SETUP_RESET = 8'h00;
  localparam int GRSE_NUM_SETUPS = 8;
  localparam int GRSE_DIG_W = 16;
  localparam int GRSE_ROWS = 8;

  // bus command strobes, each a one-cycle pulse
  typedef struct packed {
    logic my_talk;
    logic my_listen;
    logic untalk;
    logic unlisten;
    logic ifc;
    logic llo;
    logic gtl;
    logic dcl;
    logic sdc;
    logic get;
  } grse_bus_cmd_t;

  // command string parser events
  typedef struct packed {
    logic cmd_valid;
    logic cmd_known;
    logic option_ok;
    logic run_marker;
  } grse_parse_t;

  // front panel key presses, one-cycle pulses
  typedef struct packed {
    logic local_key;
    logic digital_io_display_key;
    logic other_key;
  } grse_keys_t;

  // lamps; rows A..H map to bit 0..7 of each column
  typedef struct packed {
    logic far_control_lamp;
    logic talk_lamp;
    logic listen_lamp;
    logic fault_lamp;
    logic dio_mode;
    logic [7:0] col_a;
    logic [7:0] col_b;
    logic [7:0] col_c;
    logic [7:0] col_d;
  } grse_lamps_t;

  typedef enum logic [1:0] {
    GRSE_TRIG_IDLE = 2'b00,
    GRSE_TRIG_CHANGING = 2'b01,
    GRSE_TRIG_SETTLING = 2'b11
  } grse_trig_state_t;

  localparam logic [2:0] GRSE_SRC_BUS = 3'h5;

endpackage

// [core/grse_dio_map.sv]
// digital input and output lamp map for the display mode
`timescale 1ns/1ps
module grse_dio_map
  import grse_pkg::*;
#(
  parameter int DIG_W = GRSE_DIG_W
) (
  input wire logic [DIG_W-1:0] dig_in,
  input wire logic [DIG_W-1:0] dig_out,
  output logic [7:0] in_col1,
  output logic [7:0] in_col2,
  output logic [7:0] out_col1,
  output logic [7:0] out_col2
);

  genvar r;
  generate
    for (r = 0; r < GRSE_ROWS; r++) begin : g_row
      assign in_col1[r] = dig_in[r];
      assign in_col2[r] = dig_in[r + GRSE_ROWS];
      // negative true: lamp lit while the line is pulled low
      assign out_col1[r] = ~dig_out[r];
      assign out_col2[r] = ~dig_out[r + GRSE_ROWS];
    end
  endgenerate

endmodule

// [core/grse_core.sv]
// remote/local state, fault latching and panel gating for the switching system
`timescale 1ns/1ps
// Summary of operation
// - known command with bad option raises fault
// - after bad option, skip through run marker
// - bad option latched in fault status word
// - loop failure lights lamp, sets flag
// - loop checked only on next loop operation
// - run marker while local flags not-remote
// - trigger during settling flagged, still processed
// - memory fault lamp lit until keypress
// - setup checksum failure clears setup, flags
// - trigger before ready ignored, flagged overrun
// - talker active on talk address, idle otherwise
// - listener active on listen address, idle otherwise
// - remote only when listened with enable true
// - in remote, keys other than local only clear faults
// - local key leaves remote unless lockout
// - local digital key toggles display mode
// - sixteen inputs shown, lit means high
// - sixteen outputs shown, lit means low
// - talking allowed regardless of remote
// - go-to-local leaves remote; clears restore defaults
// - group trigger acts only with bus source
// - interface clear forces local and idle states
module grse_core
  import grse_pkg::*;
#(
  parameter int DIG_W = GRSE_DIG_W,
  parameter int NUM_SETUPS = GRSE_NUM_SETUPS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ren,
  input wire grse_bus_cmd_t bus_cmd,
  input wire grse_parse_t parse,
  input wire grse_keys_t keys,
  input wire logic [2:0] trig_source,
  input wire logic ext_trigger,
  input wire logic change_done,
  input wire logic settled,
  input wire logic loop_op,
  input wire logic loop_ok,
  input wire logic powerup_done,
  input wire logic mem_fail,
  input wire logic [NUM_SETUPS-1:0] setup_bad,
  input wire logic [DIG_W-1:0] dig_in,
  input wire logic [DIG_W-1:0] dig_out,
  output grse_lamps_t lamps,
  output logic [GRSE_FAULT_W-1:0] fault_status_word,
  output logic [NUM_SETUPS-1:0] setup_clear,
  output logic cmd_execute,
  output logic start_change,
  output logic trigger_ready,
  output logic panel_enable,
  output logic defaults_restore
);

  ////////////////////////////////////////////////////////////////////////////
  // bus addressing and remote state
  logic talker, listener, remote, lockout;
  logic next_talker, next_listener, next_remote, next_lockout;
  logic dev_clear;
  assign dev_clear = bus_cmd.dcl | (bus_cmd.sdc & listener);
  always_comb begin
    next_talker = talker;
    next_listener = listener;
    next_remote = remote;
    next_lockout = lockout;
    // talking needs no remote state
    if (bus_cmd.my_talk) begin
      next_talker = 1'b1;
    end
    if (bus_cmd.untalk || bus_cmd.my_listen) begin
      next_talker = 1'b0;
    end
    if (bus_cmd.my_listen) begin
      next_listener = 1'b1;
    end
    if (bus_cmd.unlisten || bus_cmd.my_talk) begin
      next_listener = 1'b0;
    end
    if (bus_cmd.my_listen && ren) begin
      next_remote = 1'b1;
    end
    if (bus_cmd.llo) begin
      next_lockout = 1'b1;
    end
    if (!ren) begin
      // dropping remote enable is the only way out of lockout
      next_remote = 1'b0;
      next_lockout = 1'b0;
    end
    if (bus_cmd.gtl && listener) begin
      next_remote = 1'b0;
    end
    if (keys.local_key && remote && !lockout) begin
      next_remote = 1'b0;
    end
    if (bus_cmd.ifc) begin
      next_talker = 1'b0;
      next_listener = 1'b0;
      next_remote = 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      talker <= 1'b0;
      listener <= 1'b0;
      remote <= 1'b0;
      lockout <= 1'b0;
    end else begin
      talker <= next_talker;
      listener <= next_listener;
      remote <= next_remote;
      lockout <= next_lockout;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command string checking
  logic skipping, next_skipping, bad_option_fault, not_remote_ev, next_execute;
  assign bad_option_fault = parse.cmd_valid & parse.cmd_known & ~parse.option_ok;
  assign not_remote_ev = parse.run_marker & ~remote;
  always_comb begin
    next_skipping = skipping;
    next_execute = 1'b0;
    if (parse.run_marker) begin
      // marker ends the discard; the string it closes is dropped too
      next_skipping = 1'b0;
      next_execute = remote & ~skipping & ~bad_option_fault;
    end else if (bad_option_fault) begin
      next_skipping = 1'b1;
    end
    if (dev_clear || bus_cmd.ifc) begin
      next_skipping = 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      skipping <= 1'b0;
      cmd_execute <= 1'b0;
    end else begin
      skipping <= next_skipping;
      cmd_execute <= next_execute;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger timing
  grse_trig_state_t trig_state, next_trig_state;
  logic trig_in, overrun_ev, early_ev, next_start;
  // bus trigger counts only with the bus source selected
  assign trig_in = ext_trigger | (bus_cmd.get & listener & (trig_source == GRSE_SRC_BUS));
  assign overrun_ev = trig_in & (trig_state == GRSE_TRIG_CHANGING);
  assign early_ev = trig_in & (trig_state == GRSE_TRIG_SETTLING);
  always_comb begin
    next_trig_state = trig_state;
    next_start = 1'b0;
    case (trig_state)
      GRSE_TRIG_IDLE: begin
        if (trig_in) begin
          next_start = 1'b1;
          next_trig_state = GRSE_TRIG_CHANGING;
        end
      end
      GRSE_TRIG_CHANGING: begin
        // overrun trigger leaves the running change alone
        if (change_done) begin
          next_trig_state = GRSE_TRIG_SETTLING;
        end
      end
      GRSE_TRIG_SETTLING: begin
        if (trig_in) begin
          next_start = 1'b1;
          next_trig_state = GRSE_TRIG_CHANGING;
        end else if (settled) begin
          next_trig_state = GRSE_TRIG_IDLE;
        end
      end
      default: begin
        next_trig_state = GRSE_TRIG_IDLE;
      end
    endcase
    if (dev_clear) begin
      next_trig_state = GRSE_TRIG_IDLE;
      next_start = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      trig_state <= GRSE_TRIG_IDLE;
      start_change <= 1'b0;
      trigger_ready <= 1'b1;
      defaults_restore <= 1'b0;
    end else begin
      trig_state <= next_trig_state;
      start_change <= next_start;
      trigger_ready <= (next_trig_state != GRSE_TRIG_CHANGING);
      defaults_restore <= dev_clear;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault status word and fault lamp
  logic [GRSE_FAULT_W-1:0] faults, next_faults, fault_set;
  logic any_key, pu_seen, pu_fire;
  assign any_key = keys.local_key | keys.digital_io_display_key | keys.other_key;
  assign pu_fire = powerup_done & ~pu_seen;
  always_comb begin
    fault_set = '0;
    fault_set[GRSE_BIT_BAD_OPTION] = bad_option_fault;
    // loop health is sampled only when an operation uses the loop
    fault_set[GRSE_BIT_LOOP] = loop_op & ~loop_ok;
    fault_set[GRSE_BIT_NOT_REMOTE] = not_remote_ev;
    fault_set[GRSE_BIT_EARLY_TRIG] = early_ev;
    fault_set[GRSE_BIT_OVERRUN] = overrun_ev;
    fault_set[GRSE_BIT_SETUP] = pu_fire & (|setup_bad);
    fault_set[GRSE_BIT_MEMORY] = pu_fire & mem_fail;
    next_faults = faults;
    if (any_key || dev_clear) begin
      next_faults = GRSE_FAULT_RESET;
    end
    // a new fault in the clearing cycle is kept
    next_faults = next_faults | fault_set;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      faults <= GRSE_FAULT_RESET;
      pu_seen <= 1'b0;
      setup_clear <= '0;
    end else begin
      faults <= next_faults;
      pu_seen <= pu_seen | powerup_done;
      setup_clear <= pu_fire ? setup_bad : GRSE_SETUP_RESET[NUM_SETUPS-1:0];
    end
  end
  assign fault_status_word = faults;

  ////////////////////////////////////////////////////////////////////////////
  // panel keys and display
  logic dio_mode, next_dio_mode;
  logic [7:0] in_c1, in_c2, out_c1, out_c2;
  always_comb begin
    next_dio_mode = dio_mode;
    // keys other than local only clear faults while remote
    if (keys.digital_io_display_key && !remote) begin
      next_dio_mode = ~dio_mode;
    end
    if (next_remote) begin
      next_dio_mode = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dio_mode <= 1'b0;
      panel_enable <= 1'b1;
    end else begin
      dio_mode <= next_dio_mode;
      panel_enable <= ~next_remote;
    end
  end
  grse_dio_map #(.DIG_W(DIG_W)) u_map (
    .dig_in(dig_in),
    .dig_out(dig_out),
    .in_col1(in_c1),
    .in_col2(in_c2),
    .out_col1(out_c1),
    .out_col2(out_c2)
  );
  always_ff @(posedge mclk) begin
    if (rst) begin
      lamps <= '0;
    end else begin
      lamps.far_control_lamp <= next_remote;
      lamps.talk_lamp <= next_talker;
      lamps.listen_lamp <= next_listener;
      lamps.fault_lamp <= |next_faults;
      lamps.dio_mode <= next_dio_mode;
      lamps.col_a <= next_dio_mode ? in_c1 : 8'h00;
      lamps.col_b <= next_dio_mode ? in_c2 : 8'h00;
      lamps.col_c <= next_dio_mode ? out_c1 : 8'h00;
      lamps.col_d <= next_dio_mode ? out_c2 : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_remote_entry: assert property (@(posedge mclk) disable iff (rst)
    $rose(lamps.far_control_lamp) |-> $past(bus_cmd.my_listen) && $past(ren))
    else $error("remote entered without listen address and enable");
  a_ifc_idle: assert property (@(posedge mclk) disable iff (rst)
    bus_cmd.ifc |=> !lamps.talk_lamp && !lamps.listen_lamp && !lamps.far_control_lamp)
    else $error("interface clear left a lamp lit");
  a_talk_entry: assert property (@(posedge mclk) disable iff (rst)
    bus_cmd.my_talk && !bus_cmd.ifc |=> lamps.talk_lamp && !lamps.listen_lamp)
    else $error("talk address did not make talker only");
  a_listen_entry: assert property (@(posedge mclk) disable iff (rst)
    bus_cmd.my_listen && !bus_cmd.ifc |=> lamps.listen_lamp && !lamps.talk_lamp)
    else $error("listen address did not make listener only");
  a_bad_option: assert property (@(posedge mclk) disable iff (rst)
    bad_option_fault |=> fault_status_word[GRSE_BIT_BAD_OPTION] && lamps.fault_lamp)
    else $error("bad option not latched");
  // marker three cycles after the bad option, nothing clearing in between
  a_skip_marker: assert property (@(posedge mclk) disable iff (rst)
    bad_option_fault && !parse.run_marker && !dev_clear && !bus_cmd.ifc
      ##1 (!parse.run_marker && !dev_clear && !bus_cmd.ifc)[*2]
      ##1 parse.run_marker |=> !cmd_execute)
    else $error("string with bad option was executed");
  a_not_remote: assert property (@(posedge mclk) disable iff (rst)
    parse.run_marker && !remote |=> fault_status_word[GRSE_BIT_NOT_REMOTE] && !cmd_execute)
    else $error("run marker in local not flagged");
  a_overrun_hold: assert property (@(posedge mclk) disable iff (rst)
    overrun_ev && !dev_clear |=> !start_change && fault_status_word[GRSE_BIT_OVERRUN])
    else $error("overrun trigger restarted change or was not flagged");
  a_early_trig: assert property (@(posedge mclk) disable iff (rst)
    early_ev && !dev_clear |=> start_change && fault_status_word[GRSE_BIT_EARLY_TRIG])
    else $error("early trigger not processed and flagged");
  a_lockout_key: assert property (@(posedge mclk) disable iff (rst)
    remote && lockout && ren && !bus_cmd.gtl && !bus_cmd.ifc |=> lamps.far_control_lamp)
    else $error("remote left under lockout");
  a_remote_panel: assert property (@(posedge mclk) disable iff (rst)
    remote && keys.digital_io_display_key |=> !lamps.dio_mode)
    else $error("display key acted in remote");
  a_loop_fault: assert property (@(posedge mclk) disable iff (rst)
    !loop_op |=> !$rose(fault_status_word[GRSE_BIT_LOOP]))
    else $error("loop fault raised without loop operation");
  c_remote: cover property (@(posedge mclk) disable iff (rst) $rose(lamps.far_control_lamp));
  c_overrun: cover property (@(posedge mclk) disable iff (rst) overrun_ev);
  c_dio: cover property (@(posedge mclk) disable iff (rst) $rose(lamps.dio_mode));
  c_skip: cover property (@(posedge mclk) disable iff (rst) skipping && parse.run_marker);
endmodule

// [sim/grse_host_model.sv]
// bus controller model: interface commands and parsed string events
`timescale 1ns/1ps
module grse_host_model
  import grse_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] op,
  input wire logic go,
  output logic ren,
  output grse_bus_cmd_t bus_cmd,
  output grse_parse_t parse
);
  ////////////////////////////////////////////////////////////////////////
  // ops 0..9 follow the command struct order; a..e are ren and string events
  // commands last one cycle; ren is a level kept between requests
  always @(posedge mclk) begin
    if (rst) begin
      ren <= 1'b0;
      bus_cmd <= '0;
      parse <= '0;
    end else begin
      bus_cmd <= grse_bus_cmd_t'((go && op < 4'hA) ? (10'h200 >> op) : 10'h000);
      if (go && op == 4'hA) begin
        ren <= 1'b1;
      end
      if (go && op == 4'hB) begin
        ren <= 1'b0;
      end
      case (go ? op : 4'h0)
        4'hC: parse <= grse_parse_t'(4'h1);
        4'hD: parse <= grse_parse_t'(4'hE);
        4'hE: parse <= grse_parse_t'(4'hC);
        default: parse <= '0;
      endcase
    end
  end
endmodule

// [sim/test_grse_core.sv]
// self-checking bench for the remote state and fault block
`timescale 1ns/1ps
module test_grse_core
  import grse_pkg::*;
();
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] op = 4'h0;
  logic go = 1'b0;
  logic ren;
  grse_bus_cmd_t bus_cmd;
  grse_parse_t parse;
  grse_keys_t keys = '0;
  logic [2:0] trig_source = 3'h0;
  logic ext_trigger = 1'b0;
  logic change_done = 1'b0;
  logic settled = 1'b0;
  logic loop_op = 1'b0;
  logic loop_ok = 1'b1;
  logic powerup_done = 1'b0;
  logic mem_fail = 1'b0;
  logic [7:0] setup_bad = 8'h00;
  logic [15:0] dig_in = 16'h0000;
  logic [15:0] dig_out = 16'h0000;
  grse_lamps_t lamps;
  logic [7:0] fault_status_word;
  logic [7:0] setup_clear;
  logic cmd_execute;
  logic start_change;
  logic trigger_ready;
  logic panel_enable;
  logic defaults_restore;
  int fail_count = 0;
  int samples_checked = 0;
  int seed = 32'h5d7e;

  always #25 mclk = ~mclk;

  grse_host_model u_grse_host_model (.mclk(mclk), .rst(rst), .op(op), .go(go), .ren(ren),
    .bus_cmd(bus_cmd), .parse(parse));

  grse_core u_grse_core (.mclk(mclk), .rst(rst), .ren(ren), .bus_cmd(bus_cmd), .parse(parse),
    .keys(keys), .trig_source(trig_source), .ext_trigger(ext_trigger),
    .change_done(change_done), .settled(settled), .loop_op(loop_op), .loop_ok(loop_ok),
    .powerup_done(powerup_done), .mem_fail(mem_fail), .setup_bad(setup_bad),
    .dig_in(dig_in), .dig_out(dig_out), .lamps(lamps), .fault_status_word(fault_status_word),
    .setup_clear(setup_clear), .cmd_execute(cmd_execute), .start_change(start_change),
    .trigger_ready(trigger_ready), .panel_enable(panel_enable),
    .defaults_restore(defaults_restore));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_word(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // model registers the request, so the design answers two edges later
  task automatic host(input logic [3:0] o);
    @(posedge mclk);
    op <= o;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic strobe(input int which);
    @(posedge mclk);
    case (which)
      0: ext_trigger <= 1'b1;
      1: change_done <= 1'b1;
      2: loop_op <= 1'b1;
      3: keys <= 3'h4;
      4: keys <= 3'h2;
      default: keys <= 3'h1;
    endcase
    @(posedge mclk);
    ext_trigger <= 1'b0;
    change_done <= 1'b0;
    loop_op <= 1'b0;
    keys <= '0;
    #1;
  endtask

  task automatic end_sim;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge mclk);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk_word("reset faults", 8'h00, fault_status_word);
    chk_bit("reset ready", 1'b1, trigger_ready);
    chk_bit("reset panel", 1'b1, panel_enable);
    @(posedge mclk);
    powerup_done <= 1'b1;
    mem_fail <= 1'b1;
    setup_bad <= 8'h24;
    @(posedge mclk);
    #1;
    chk_word("setup_clear", 8'h24, setup_clear);
    chk_word("powerup faults", 8'h60, fault_status_word);
    chk_bit("fault_lamp", 1'b1, lamps.fault_lamp);
    strobe(5);
    chk_bit("fault_lamp key", 1'b0, lamps.fault_lamp);
    chk_word("setup_clear", 8'h00, setup_clear);
    host(4'h1);
    chk_bit("listen_lamp", 1'b1, lamps.listen_lamp);
    chk_bit("far_control_lamp", 1'b0, lamps.far_control_lamp);
    host(4'hC);
    chk_bit("cmd_execute local", 1'b0, cmd_execute);
    chk_word("not remote", 8'h04, fault_status_word);
    strobe(5);
    host(4'hA);
    chk_bit("ren alone", 1'b0, lamps.far_control_lamp);
    host(4'h1);
    chk_bit("far_control_lamp", 1'b1, lamps.far_control_lamp);
    chk_bit("panel_enable", 1'b0, panel_enable);
    strobe(4);
    chk_bit("dio remote", 1'b0, lamps.dio_mode);
    host(4'hC);
    chk_bit("cmd_execute", 1'b1, cmd_execute);
    host(4'hD);
    chk_word("good option", 8'h00, fault_status_word);
    host(4'hE);
    chk_word("bad option", 8'h01, fault_status_word);
    host(4'hC);
    chk_bit("skipped string", 1'b0, cmd_execute);
    host(4'hC);
    chk_bit("next string", 1'b1, cmd_execute);
    host(4'h0);
    chk_bit("talk_lamp", 1'b1, lamps.talk_lamp);
    chk_bit("listen by talk", 1'b0, lamps.listen_lamp);
    host(4'h2);
    chk_bit("untalk", 1'b0, lamps.talk_lamp);
    host(4'h0);
    host(4'h1);
    chk_bit("talk by listen", 1'b0, lamps.talk_lamp);
    host(4'h3);
    chk_bit("unlisten", 1'b0, lamps.listen_lamp);
    host(4'h7);
    chk_bit("defaults_restore", 1'b1, defaults_restore);
    chk_word("clear faults", 8'h00, fault_status_word);
    host(4'h1);
    host(4'h8);
    chk_bit("sdc restore", 1'b1, defaults_restore);
    strobe(3);
    chk_bit("local key", 1'b0, lamps.far_control_lamp);
    chk_bit("panel back", 1'b1, panel_enable);
    host(4'h1);
    host(4'h5);
    strobe(3);
    chk_bit("lockout", 1'b1, lamps.far_control_lamp);
    host(4'h6);
    chk_bit("go to local", 1'b0, lamps.far_control_lamp);
    host(4'hB);
    host(4'hA);
    host(4'h1);
    host(4'h4);
    chk_bit("ifc remote", 1'b0, lamps.far_control_lamp);
    chk_bit("ifc listen", 1'b0, lamps.listen_lamp);
    host(4'h0);
    chk_bit("talk local", 1'b1, lamps.talk_lamp);
    host(4'h4);
    chk_bit("ifc talk", 1'b0, lamps.talk_lamp);
    strobe(4);
    chk_bit("dio on", 1'b1, lamps.dio_mode);
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      dig_in <= (i == 0) ? 16'h8001 : 16'($random(seed));
      dig_out <= (i == 0) ? 16'h0180 : 16'($random(seed));
      repeat (2) @(posedge mclk);
      #1;
      chk_word("col_a", dig_in[7:0], lamps.col_a);
      chk_word("col_b", dig_in[15:8], lamps.col_b);
      chk_word("col_c", ~dig_out[7:0], lamps.col_c);
      chk_word("col_d", ~dig_out[15:8], lamps.col_d);
    end
    strobe(4);
    chk_bit("dio off", 1'b0, lamps.dio_mode);
    chk_word("col_a off", 8'h00, lamps.col_a);
    strobe(0);
    chk_bit("start_change", 1'b1, start_change);
    chk_bit("ready low", 1'b0, trigger_ready);
    strobe(0);
    chk_bit("overrun ignored", 1'b0, start_change);
    chk_word("overrun", 8'h10, fault_status_word);
    strobe(1);
    chk_bit("ready back", 1'b1, trigger_ready);
    strobe(0);
    chk_bit("early processed", 1'b1, start_change);
    chk_word("early flag", 8'h18, fault_status_word);
    strobe(1);
    settled <= 1'b1;
    host(4'h1);
    trig_source <= GRSE_SRC_BUS;
    host(4'h9);
    chk_bit("get bus", 1'b1, start_change);
    strobe(1);
    trig_source <= 3'(($random(seed) & 3) + 1);
    host(4'h9);
    chk_bit("get other", 1'b0, start_change);
    loop_ok <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk_bit("loop idle", 1'b0, fault_status_word[GRSE_BIT_LOOP]);
    strobe(2);
    chk_bit("loop fault", 1'b1, fault_status_word[GRSE_BIT_LOOP]);
    chk_bit("loop lamp", 1'b1, lamps.fault_lamp);
    end_sim();
  end
endmodule
